// ==== core/icp_pkg.sv ====
// constants, types and word-length decode for the two-wire control-port slave
package icp_pkg;


// ----------------------------------------
// bus and framing
// ----------------------------------------
localparam logic [6:0] ICP_DEV_ADDR_BASE = 7'h14;
localparam logic [3:0] ICP_BITS_PER_BYTE = 4'h8;
localparam logic [3:0] ICP_TX_LAST_BIT = 4'h7;
localparam int ICP_WORD_W = 48;

// ----------------------------------------
// subaddress map
// ----------------------------------------
localparam logic [15:0] ICP_PARAM_END = 16'h03ff;
localparam logic [15:0] ICP_PROG_BEG = 16'h0400;
localparam logic [15:0] ICP_PROG_END = 16'h0e00;
localparam logic [15:0] ICP_SLEW_BEG = 16'h1000;
localparam logic [15:0] ICP_SAFE_DATA_END = 16'h1044;
localparam logic [15:0] ICP_SAFE_ADDR_BEG = 16'h1045;
localparam logic [15:0] ICP_CAPT_BEG = 16'h104a;
localparam logic [15:0] ICP_CAPT_END = 16'h104f;
localparam logic [15:0] ICP_OUT_CAPT_BEG = 16'h1050;
localparam logic [15:0] ICP_CTRL_END = 16'h105a;
localparam logic [15:0] ICP_MODULO_REG = 16'h1053;
localparam logic [15:0] ICP_SIN_REG = 16'h1055;
localparam logic [15:0] ICP_SRC_REG = 16'h1056;
localparam logic [15:0] ICP_SUBADDR_MAX = 16'h110d;
localparam logic [15:0] ICP_PTR_RESET = 16'h0000;

// ----------------------------------------
// word lengths in bytes
// ----------------------------------------
localparam logic [2:0] ICP_LEN_NONE = 3'h0;
localparam logic [2:0] ICP_LEN_BYTE = 3'h1;
localparam logic [2:0] ICP_LEN_REG = 3'h2;
localparam logic [2:0] ICP_LEN_CAPT_RD = 3'h3;
localparam logic [2:0] ICP_LEN_PARAM = 3'h4;
localparam logic [2:0] ICP_LEN_SLEW = 3'h5;
localparam logic [2:0] ICP_LEN_PROG = 3'h6;

// ----------------------------------------
// types
// ----------------------------------------
typedef enum {ICP_ST_IDLE, ICP_ST_RX, ICP_ST_ACK, ICP_ST_TX, ICP_ST_MACK, ICP_ST_PREP} icp_state_t;
typedef enum {ICP_PH_ADDR, ICP_PH_SUB_HI, ICP_PH_SUB_LO, ICP_PH_DATA} icp_phase_t;

// word length of a location; zero marks a subaddress that does not exist
function automatic logic [2:0] icp_word_len(input logic [15:0] a, input logic rd);
    logic [2:0] n;
    n = ICP_LEN_NONE;
    if (a <= ICP_PARAM_END) begin
        n = ICP_LEN_PARAM;
    end else if (a >= ICP_PROG_BEG && a <= ICP_PROG_END) begin
        n = ICP_LEN_PROG;
    end else if (a >= ICP_SLEW_BEG && a <= ICP_SAFE_DATA_END) begin
        n = ICP_LEN_SLEW;
    end else if (a >= ICP_SAFE_ADDR_BEG && a <= ICP_CAPT_END) begin
        n = (rd && a >= ICP_CAPT_BEG) ? ICP_LEN_CAPT_RD : ICP_LEN_REG;
    end else if (a >= ICP_OUT_CAPT_BEG && a <= ICP_CTRL_END) begin
        if (a == ICP_MODULO_REG || a == ICP_SIN_REG || a == ICP_SRC_REG) begin
            n = ICP_LEN_BYTE;
        end else begin
            n = ICP_LEN_REG;
        end
    end else if (a == ICP_SUBADDR_MAX) begin
        n = ICP_LEN_REG;
    end
    return n;
endfunction

endpackage

// ==== core/icp_pin_sync.sv ====
// pin synchroniser and bus-condition detector for the control-port slave
`timescale 1ns/1ps
module icp_pin_sync (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // raw pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic strap_in,
    // synchronised levels and events
    output logic sda_out,
    output logic strap_out,
    output logic scl_rise_out,
    output logic scl_fall_out,
    output logic start_out,
    output logic stop_out
);
    // ----------------------------------------
    // two-flop sync plus one delay stage
    // ----------------------------------------
    logic [2:0] pin_raw;
    logic [2:0] sync_r;
    logic [2:0] dly_r;

    assign pin_raw = {strap_in, sda_in, scl_in};

    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_sync
            localparam logic RST_LVL = (i == 2) ? 1'b0 : 1'b1;
            logic meta_r;
            logic sync_bit_r;
            logic dly_bit_r;
            always_ff @(posedge core_clk_in or posedge rst_in) begin
                if (rst_in) begin
                    meta_r <= RST_LVL;
                    sync_bit_r <= RST_LVL;
                    dly_bit_r <= RST_LVL;
                end else begin
                    meta_r <= pin_raw[i];
                    sync_bit_r <= meta_r;
                    dly_bit_r <= sync_bit_r;
                end
            end
            assign sync_r[i] = sync_bit_r;
            assign dly_r[i] = dly_bit_r;
        end
    endgenerate

    // ----------------------------------------
    // edges and start/stop conditions
    // ----------------------------------------
    assign sda_out = sync_r[1];
    assign strap_out = sync_r[2];
    assign scl_rise_out = sync_r[0] & ~dly_r[0];
    assign scl_fall_out = ~sync_r[0] & dly_r[0];
    assign start_out = sync_r[0] & dly_r[0] & ~sync_r[1] & dly_r[1];
    assign stop_out = sync_r[0] & dly_r[0] & sync_r[1] & ~dly_r[1];
endmodule

// ==== core/icp_ctrl_port.sv ====
// two-wire control-port slave: addressing, subaddress pointer, burst words
`timescale 1ns/1ps
module icp_ctrl_port (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_drv_out,
    output logic sda_oe_out,
    input wire logic address_select_strap_in,
    // write side towards registers and memories
    output logic wr_en_out,
    output logic [15:0] wr_addr_out,
    output logic [icp_pkg::ICP_WORD_W-1:0] wr_data_out,
    output logic [2:0] wr_len_out,
    // read side towards registers and memories
    output logic rd_en_out,
    output logic [15:0] rd_addr_out,
    output logic [2:0] rd_len_out,
    input wire logic [icp_pkg::ICP_WORD_W-1:0] rd_data_in,
    // status
    output logic busy_out
);
    import icp_pkg::*;

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic sda_s;
    logic strap_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    icp_state_t state_r;
    icp_phase_t phase_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] tx_sh_r;
    logic rw_r;
    logic [7:0] sub_hi_r;
    logic [15:0] ptr_r;
    logic [2:0] len_r;
    logic [2:0] byte_cnt_r;
    logic overrun_r;
    logic [ICP_WORD_W-1:0] word_r;
    logic [ICP_WORD_W-1:0] rd_word_r;
    logic rd_cap_r;
    logic sda_oe_r;
    logic sda_drv_r;
    logic wr_en_r;
    logic [15:0] wr_addr_r;
    logic [ICP_WORD_W-1:0] wr_data_r;
    logic [2:0] wr_len_r;
    logic rd_en_r;
    logic [15:0] rd_addr_r;
    logic [2:0] rd_len_r;
    logic busy_r;

    logic rx_end;
    logic ack_end;
    logic accept;
    logic acc_sublo;
    logic rd_start;
    logic wr_byte_done;
    logic rd_byte_done;
    logic word_last;
    logic [15:0] sub_addr;
    logic [15:0] next_addr;
    logic nxt_ok;
    logic [15:0] step_ptr;
    logic [2:0] tx_idx;
    logic [ICP_WORD_W-1:0] tx_word_sh;
    logic [7:0] tx_byte;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    icp_pin_sync u_sync (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .strap_in(address_select_strap_in),
        .sda_out(sda_s),
        .strap_out(strap_s),
        .scl_rise_out(scl_rise),
        .scl_fall_out(scl_fall),
        .start_out(start_det),
        .stop_out(stop_det)
    );

    // ----------------------------------------
    // byte events and decisions
    // ----------------------------------------
    assign rx_end = (state_r == ICP_ST_RX) && scl_fall && (bit_cnt_r == ICP_BITS_PER_BYTE);
    assign ack_end = (state_r == ICP_ST_ACK) && scl_fall;
    assign sub_addr = {sub_hi_r, shift_r};
    assign next_addr = 16'(ptr_r + 16'h0001);
    assign nxt_ok = (ptr_r != ICP_SUBADDR_MAX) && (icp_word_len(next_addr, rw_r) != ICP_LEN_NONE);
    assign step_ptr = nxt_ok ? next_addr : ptr_r;
    assign word_last = (byte_cnt_r == 3'(len_r - 3'h1));

    always_comb begin
        case (phase_r)
            ICP_PH_ADDR: accept = (shift_r[7:1] == {ICP_DEV_ADDR_BASE[6:1], strap_s});
            ICP_PH_SUB_HI: accept = 1'b1;
            ICP_PH_SUB_LO: accept = (icp_word_len(sub_addr, 1'b0) != ICP_LEN_NONE);
            ICP_PH_DATA: accept = !overrun_r;
            default: accept = 1'b0;
        endcase
    end

    assign acc_sublo = rx_end && accept && (phase_r == ICP_PH_SUB_LO);
    assign rd_start = rx_end && accept && (phase_r == ICP_PH_ADDR) && shift_r[0];
    assign wr_byte_done = ack_end && (phase_r == ICP_PH_DATA) && !rw_r;
    assign rd_byte_done = (state_r == ICP_ST_MACK) && scl_rise && !sda_s;

    assign tx_idx = 3'(len_r - 3'h1 - byte_cnt_r);
    assign tx_word_sh = rd_word_r >> {tx_idx, 3'h0};
    assign tx_byte = tx_word_sh[7:0];

    // ----------------------------------------
    // protocol state machine
    // ----------------------------------------
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= ICP_ST_IDLE;
            phase_r <= ICP_PH_ADDR;
            bit_cnt_r <= 4'h0;
        end else if (stop_det) begin
            state_r <= ICP_ST_IDLE;
        end else if (start_det) begin
            state_r <= ICP_ST_RX;
            phase_r <= ICP_PH_ADDR;
            bit_cnt_r <= 4'h0;
        end else begin
            case (state_r)
                ICP_ST_RX: begin
                    if (rx_end) begin
                        state_r <= accept ? ICP_ST_ACK : ICP_ST_IDLE;
                    end else if (scl_rise && bit_cnt_r != ICP_BITS_PER_BYTE) begin
                        bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
                    end
                end
                ICP_ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_r <= 4'h0;
                        case (phase_r)
                            ICP_PH_ADDR: begin
                                state_r <= rw_r ? ICP_ST_TX : ICP_ST_RX;
                                phase_r <= rw_r ? ICP_PH_DATA : ICP_PH_SUB_HI;
                            end
                            ICP_PH_SUB_HI: begin
                                state_r <= ICP_ST_RX;
                                phase_r <= ICP_PH_SUB_LO;
                            end
                            default: begin
                                state_r <= ICP_ST_RX;
                                phase_r <= ICP_PH_DATA;
                            end
                        endcase
                    end
                end
                ICP_ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_r == ICP_TX_LAST_BIT) begin
                            state_r <= ICP_ST_MACK;
                        end else begin
                            bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
                        end
                    end
                end
                ICP_ST_MACK: begin
                    if (scl_rise) begin
                        state_r <= sda_s ? ICP_ST_IDLE : ICP_ST_PREP;
                    end
                end
                ICP_ST_PREP: begin
                    if (scl_fall) begin
                        state_r <= ICP_ST_TX;
                        bit_cnt_r <= 4'h0;
                    end
                end
                default: state_r <= ICP_ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // receive shifter and header capture
    // ----------------------------------------
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            shift_r <= 8'h00;
        end else if (state_r == ICP_ST_RX && scl_rise && bit_cnt_r != ICP_BITS_PER_BYTE) begin
            shift_r <= {shift_r[6:0], sda_s};
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rw_r <= 1'b0;
            sub_hi_r <= 8'h00;
        end else if (rx_end && accept) begin
            if (phase_r == ICP_PH_ADDR) begin
                rw_r <= shift_r[0];
            end
            if (phase_r == ICP_PH_SUB_HI) begin
                sub_hi_r <= shift_r;
            end
        end
    end

    // ----------------------------------------
    // subaddress pointer and word counting
    // ----------------------------------------
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ptr_r <= ICP_PTR_RESET;
            len_r <= ICP_LEN_PARAM;
            byte_cnt_r <= 3'h0;
            overrun_r <= 1'b0;
        end else if (acc_sublo) begin
            ptr_r <= sub_addr;
            len_r <= icp_word_len(sub_addr, 1'b0);
            byte_cnt_r <= 3'h0;
            overrun_r <= 1'b0;
        end else if (rd_start) begin
            len_r <= icp_word_len(ptr_r, 1'b1);
            byte_cnt_r <= 3'h0;
        end else if (wr_byte_done || rd_byte_done) begin
            if (word_last) begin
                byte_cnt_r <= 3'h0;
                ptr_r <= step_ptr;
                if (nxt_ok) begin
                    len_r <= icp_word_len(next_addr, rw_r);
                end
                if (!nxt_ok && !rw_r) begin
                    overrun_r <= 1'b1;
                end
            end else begin
                byte_cnt_r <= 3'(byte_cnt_r + 3'h1);
            end
        end
    end

    // ----------------------------------------
    // write word assembly and commit
    // ----------------------------------------
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            word_r <= 48'h0;
        end else if (acc_sublo || (wr_byte_done && word_last)) begin
            word_r <= 48'h0;
        end else if (rx_end && accept && phase_r == ICP_PH_DATA) begin
            word_r <= {word_r[ICP_WORD_W-9:0], shift_r};
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_en_r <= 1'b0;
            wr_addr_r <= 16'h0000;
            wr_data_r <= 48'h0;
            wr_len_r <= 3'h0;
        end else begin
            wr_en_r <= 1'b0;
            if (wr_byte_done && word_last) begin
                wr_en_r <= 1'b1;
                wr_addr_r <= ptr_r;
                wr_data_r <= word_r;
                wr_len_r <= len_r;
            end
        end
    end

    // ----------------------------------------
    // read fetch
    // ----------------------------------------
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_en_r <= 1'b0;
            rd_cap_r <= 1'b0;
            rd_addr_r <= 16'h0000;
            rd_len_r <= 3'h0;
            rd_word_r <= 48'h0;
        end else begin
            rd_en_r <= 1'b0;
            rd_cap_r <= rd_en_r;
            if (rd_start) begin
                rd_en_r <= 1'b1;
                rd_addr_r <= ptr_r;
                rd_len_r <= icp_word_len(ptr_r, 1'b1);
            end else if (rd_byte_done && word_last) begin
                rd_en_r <= 1'b1;
                rd_addr_r <= step_ptr;
                rd_len_r <= icp_word_len(step_ptr, 1'b1);
            end
            if (rd_cap_r) begin
                rd_word_r <= rd_data_in;
            end
        end
    end

    // ----------------------------------------
    // data line drive, open drain
    // ----------------------------------------
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sda_oe_r <= 1'b0;
            tx_sh_r <= 8'h00;
        end else if (start_det || stop_det) begin
            sda_oe_r <= 1'b0;
        end else if (rx_end) begin
            sda_oe_r <= accept;
        end else if (ack_end) begin
            if (phase_r == ICP_PH_ADDR && rw_r) begin
                sda_oe_r <= ~tx_byte[7];
                tx_sh_r <= tx_byte;
            end else begin
                sda_oe_r <= 1'b0;
            end
        end else if (state_r == ICP_ST_TX && scl_fall) begin
            if (bit_cnt_r == ICP_TX_LAST_BIT) begin
                sda_oe_r <= 1'b0;
            end else begin
                sda_oe_r <= ~tx_sh_r[6];
                tx_sh_r <= {tx_sh_r[6:0], 1'b0};
            end
        end else if (state_r == ICP_ST_PREP && scl_fall) begin
            sda_oe_r <= ~tx_byte[7];
            tx_sh_r <= tx_byte;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sda_drv_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            sda_drv_r <= 1'b0;
            busy_r <= (state_r != ICP_ST_IDLE);
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign sda_drv_out = sda_drv_r;
    assign sda_oe_out = sda_oe_r;
    assign wr_en_out = wr_en_r;
    assign wr_addr_out = wr_addr_r;
    assign wr_data_out = wr_data_r;
    assign wr_len_out = wr_len_r;
    assign rd_en_out = rd_en_r;
    assign rd_addr_out = rd_addr_r;
    assign rd_len_out = rd_len_r;
    assign busy_out = busy_r;
endmodule

// ==== testbench/icp_chk.sv ====
// port checker for the two-wire control-port slave
`timescale 1ns/1ps
module icp_chk (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // bus
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_drv_out,
    input wire logic sda_oe_out,
    // memory side and status
    input wire logic wr_en_out,
    input wire logic [2:0] wr_len_out,
    input wire logic rd_en_out,
    input wire logic [2:0] rd_len_out,
    input wire logic busy_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    AST_DRV_LOW: assert property (sda_oe_out |-> sda_drv_out == 1'b0)
        else $error("data line driven high");
    AST_OE_BUSY: assert property (sda_oe_out |-> busy_out)
        else $error("data pulled low while idle");
    AST_OE_SCL_LOW: assert property ($changed(sda_oe_out) |-> !scl_in)
        else $error("data drive changed while clock high");
    AST_OE_HOLD: assert property ($rose(sda_oe_out) |-> sda_oe_out [*8])
        else $error("data drive too short");
    AST_STOP_IDLE: assert property (scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:10] !busy_out)
        else $error("no idle after stop");
    AST_WR_ONE: assert property (wr_en_out |=> !wr_en_out)
        else $error("commit longer than one cycle");
    AST_RD_ONE: assert property (rd_en_out |=> !rd_en_out [*8])
        else $error("fetches too close");
    AST_WR_LEN: assert property (wr_en_out |-> wr_len_out inside {[3'h1:3'h6]} && !scl_in)
        else $error("bad commit length or timing");
    AST_RD_LEN: assert property (rd_en_out |-> rd_len_out inside {[3'h1:3'h6]} && busy_out)
        else $error("bad fetch length");
endmodule

// ==== testbench/icp_bus_master.sv ====
// two-wire bus master model, open-drain data, clock still between frames
`timescale 1ns/1ps
module icp_bus_master (
    // clock
    input wire logic core_clk_in,
    // bus
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask
    // start or repeated start, clock left low
    task automatic start_c();
        sda_out = 1'b1;
        wt(6);
        scl_out = 1'b1;
        wt(4);
        sda_out = 1'b0;
        wt(4);
        scl_out = 1'b0;
        wt(4);
    endtask
    task automatic stop_c();
        sda_out = 1'b0;
        wt(6);
        scl_out = 1'b1;
        wt(4);
        sda_out = 1'b1;
        wt(8);
    endtask
    task automatic bit_x(input logic b, output logic r);
        sda_out = b;
        wt(4);
        scl_out = 1'b1;
        wt(4);
        r = sda_in;
        wt(4);
        scl_out = 1'b0;
        wt(4);
    endtask
    // byte msb first, then ninth bit pulled low when ack_m
    task automatic byte_x(input logic [7:0] d, input logic ack_m, output logic [7:0] q,
                          output logic acked);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], q[i]);
        end
        bit_x(~ack_m, r);
        acked = ~r;
    endtask
endmodule

// ==== testbench/tb_top.sv ====
// self-checking bench for the two-wire control-port slave
`timescale 1ns/1ps
module tb_top;
    import icp_pkg::*;
    logic core_clk_in, rst_in, strap, sda_m, scl, sda_w, sda_drv, sda_oe, wr_en, rd_en, busy;
    logic [15:0] wr_addr, rd_addr;
    logic [ICP_WORD_W-1:0] wr_data, rd_data;
    logic [2:0] wr_len, rd_len;
    logic [66:0] e;
    logic [66:0] exp_q[$];
    logic [7:0] lf;
    int fail_count = 0;
    int checked = 0;
    assign sda_w = sda_m & ~(sda_oe & ~sda_drv);
    icp_ctrl_port i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .scl_in(scl),
        .sda_in(sda_w), .sda_drv_out(sda_drv), .sda_oe_out(sda_oe),
        .address_select_strap_in(strap), .wr_en_out(wr_en), .wr_addr_out(wr_addr),
        .wr_data_out(wr_data), .wr_len_out(wr_len), .rd_en_out(rd_en), .rd_addr_out(rd_addr),
        .rd_len_out(rd_len), .rd_data_in(rd_data), .busy_out(busy));
    icp_bus_master i_m (.core_clk_in(core_clk_in), .sda_in(sda_w), .scl_out(scl),
        .sda_out(sda_m));
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end
    function automatic logic [47:0] pat(input logic [15:0] a);
        return {a, ~a, a ^ 16'h5a5a};
    endfunction
    function automatic logic [7:0] nxt(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    // memory: word valid one cycle after fetch, scrambled otherwise
    always @(posedge core_clk_in) begin
        rd_data <= rst_in ? '0 : (rd_en ? pat(rd_addr) : ~rd_data);
    end
    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    always @(posedge core_clk_in) begin
        if (wr_en === 1'b1) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
            chk({wr_addr, wr_len, wr_data} === e, "commit");
        end
    end
    task automatic send(input logic [7:0] b, input logic ex);
        logic [7:0] q;
        logic a;
        i_m.byte_x(b, 1'b0, q, a);
        chk(a === ex, "slave ack");
    endtask
    task automatic head(input logic [7:0] a, input logic [15:0] s);
        i_m.start_c();
        send(a, 1'b1);
        send(s[15:8], 1'b1);
        send(s[7:0], 1'b1);
    endtask
    task automatic wwords(input logic [15:0] a, input int len, input int nw);
        logic [47:0] w;
        for (int k = 0; k < nw; k++) begin
            w = '0;
            for (int j = 0; j < len; j++) begin
                lf = nxt(lf);
                w = {w[39:0], lf};
                if (j == len - 1) exp_q.push_back({a + k[15:0], len[2:0], w});
                send(lf, 1'b1);
            end
        end
    endtask
    task automatic rwords(input logic [15:0] a, input int len, input int nb, input logic step);
        logic [7:0] q;
        logic ak;
        logic [47:0] w;
        for (int i = 0; i < nb; i++) begin
            w = pat(step ? a + 16'(i / len) : a) >> (8 * (len - 1 - i % len));
            i_m.byte_x(8'hff, i < nb - 1, q, ak);
            chk(q === w[7:0], "read byte");
        end
    endtask
    task automatic report_and_stop();
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #300000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        lf = 8'h29;
        strap = 1'b0;
        rst_in = 1'b1;
        i_m.wt(4);
        rst_in = 1'b0;
        i_m.wt(4);
        head(8'h28, 16'h0005);
        wwords(16'h0005, 4, 2);
        send(8'h3c, 1'b1);
        i_m.stop_c();
        i_m.start_c();
        send(8'h2a, 1'b0);
        i_m.stop_c();
        strap = 1'b1;
        i_m.wt(4);
        head(8'h2a, 16'h1055);
        wwords(16'h1055, 1, 2);
        i_m.stop_c();
        i_m.start_c();
        send(8'h2a, 1'b1);
        send(8'h0f, 1'b1);
        send(8'h00, 1'b0);
        i_m.stop_c();
        head(8'h2a, 16'h110d);
        wwords(16'h110d, 2, 1);
        send(8'h5a, 1'b0);
        i_m.stop_c();
        head(8'h2a, 16'h0e00);
        wwords(16'h0e00, 6, 1);
        send(8'ha5, 1'b0);
        i_m.stop_c();
        head(8'h2a, 16'h1044);
        wwords(16'h1044, 5, 1);
        wwords(16'h1045, 2, 1);
        i_m.stop_c();
        head(8'h2a, 16'h104a);
        i_m.start_c();
        send(8'h2b, 1'b1);
        rwords(16'h104a, 3, 4, 1'b1);
        i_m.stop_c();
        head(8'h2a, 16'h110d);
        i_m.start_c();
        send(8'h2b, 1'b1);
        rwords(16'h110d, 2, 4, 1'b0);
        i_m.stop_c();
        i_m.start_c();
        send(8'h2a, 1'b1);
        send(8'h00, 1'b1);
        head(8'h2a, 16'h0010);
        wwords(16'h0010, 4, 1);
        i_m.stop_c();
        chk(exp_q.size() == 0, "missing commit");
        report_and_stop();
    end
endmodule
bind icp_ctrl_port icp_chk i_chk (.core_clk_in(core_clk_in), .rst_in(rst_in), .scl_in(scl_in),
    .sda_in(sda_in), .sda_drv_out(sda_drv_out), .sda_oe_out(sda_oe_out),
    .wr_en_out(wr_en_out), .wr_len_out(wr_len_out), .rd_en_out(rd_en_out),
    .rd_len_out(rd_len_out), .busy_out(busy_out));
